// [ccit_pkg.sv]
package ccit_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_CORE_SRC = 10'h030;
  localparam logic [9:0] IDX_TMR_CLK = 10'h031;
  localparam logic [9:0] IDX_CLK_PIN = 10'h032;
  localparam logic [9:0] IDX_OSC_CTL = 10'h1e0;
  localparam logic [9:0] IDX_RELOAD = 10'h040;
  localparam logic [9:0] IDX_TMR_STAT = 10'h041;
  localparam logic [9:0] IDX_AUX_CTL = 10'h042;
  // reset values
  localparam logic [7:0] RST_CORE_SRC = 8'h00;
  localparam logic [7:0] RST_TMR_CLK = 8'h8f;
  localparam logic [7:0] RST_CLK_PIN = 8'h00;
  localparam logic [7:0] RST_OSC_CTL = 8'h00;
  localparam logic [11:0] RST_RELOAD = 12'h000;
  localparam logic [7:0] RST_AUX_CTL = 8'h00;
  // core source register
  localparam int CORE_SEL_BIT = 0;
  // clock pin register
  localparam int PIN_SRC_LSB = 0;
  localparam int FILT_BYPASS_BIT = 2;
  localparam int XTAL_ON_BIT = 3;
  localparam int XTAL_CHOOSE_BIT = 4;
  // oscillator control register
  localparam int SPEED_LSB = 0;
  localparam int SLEEP_TMR_LSB = 3;
  localparam int NO_BUZZ_BIT = 5;
  // timer clock register
  localparam int ITMR_SEL_LSB = 0;
  localparam int ITMR_DIV_LSB = 2;
  localparam int CAP_SEL_LSB = 4;
  localparam int CAP_DIV_LSB = 6;
  // auxiliary control register
  localparam int CORE_LP_BIT = 0;
  localparam int CLKPIN_EN_BIT = 1;
  localparam int DUTY_LSB = 2;
  // transient filter: samples an input must hold before it is passed
  localparam int FILT_HOLD = 3;
  // mux indices
  localparam int MUX_CORE = 0;
  localparam int MUX_ITMR = 1;
  localparam int MUX_CAP = 2;
  localparam int MUX_PIN = 3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
endpackage

// [ccit_top.sv]
`timescale 1ns/1ps
`default_nettype none
module ccit_top
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // oscillator and pin clock inputs
  input wire logic osc24_in,
  input wire logic osc32_in,
  input wire logic xtal_clk_in,
  input wire logic shared_pin_zero_in,
  // gpio requests for the shared pins
  input wire logic gpio_zero_oe,
  input wire logic gpio_one_out,
  input wire logic gpio_one_oe,
  // shared pin drive
  output logic shared_pin_zero_oe,
  output logic clock_output_pin,
  output logic shared_pin_one_oe,
  // generated clocks and control
  output logic core_clock,
  output logic osc24_run,
  output logic crystal_osc_on,
  // sleep
  input wire logic sleep_req,
  output logic detector_enable,
  output logic sleep_wake,
  output logic wdt_expire,
  // interval timer
  output logic itmr_irq
);
  ////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  assign pin_raw = {shared_pin_zero_in, xtal_clk_in, osc32_in, osc24_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      logic s1, s2, s3, lvl;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl <= 1'b0;
        end
        else
        begin
          s1 <= pin_raw[gi];
          s2 <= s1;
          s3 <= s2;
          // a change counts once the last two stages agree
          if (s2 == s3)
            lvl <= s3;
        end
      end
      assign pin_lvl[gi] = lvl;
    end
  endgenerate
  logic o24, o32, xtal, pin0;
  assign o24 = pin_lvl[0];
  assign o32 = pin_lvl[1];
  assign xtal = pin_lvl[2];
  assign pin0 = pin_lvl[3];

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] core_clock_source_config, timer_clock_config, clock_pin_config, oscillator_control, aux_control;
  logic [11:0] interval_reload_value;
  logic [11:0] count;
  logic reloading;
  logic dp_write;
  logic [9:0] dp_idx;
  logic sleep_q;
  logic [31:0] next_rdata;
  logic [9:0] a_idx;
  assign a_idx = haddr[11:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    case (a_idx)
      ccit_pkg::IDX_CORE_SRC: next_rdata = {24'h000000, core_clock_source_config};
      ccit_pkg::IDX_TMR_CLK: next_rdata = {24'h000000, timer_clock_config};
      ccit_pkg::IDX_CLK_PIN: next_rdata = {24'h000000, clock_pin_config};
      ccit_pkg::IDX_OSC_CTL: next_rdata = {24'h000000, oscillator_control};
      ccit_pkg::IDX_AUX_CTL: next_rdata = {24'h000000, aux_control};
      ccit_pkg::IDX_RELOAD: next_rdata = {20'h00000, interval_reload_value};
      ccit_pkg::IDX_TMR_STAT: next_rdata = {19'h00000, reloading, count};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_write <= 1'b0;
      dp_idx <= 10'h000;
      hrdata <= 32'h00000000;
    end
    else if (hready)
    begin
      dp_write <= hsel && htrans == ccit_pkg::HTRANS_NONSEQ && hwrite && hsize == ccit_pkg::HSIZE_WORD;
      dp_idx <= a_idx;
      if (hsel && htrans == ccit_pkg::HTRANS_NONSEQ && !hwrite)
        hrdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // speed field and all control reset to zero except the timer clock register, which resets to 8f
      core_clock_source_config <= ccit_pkg::RST_CORE_SRC;
      timer_clock_config <= ccit_pkg::RST_TMR_CLK;
      clock_pin_config <= ccit_pkg::RST_CLK_PIN;
      oscillator_control <= ccit_pkg::RST_OSC_CTL;
      aux_control <= ccit_pkg::RST_AUX_CTL;
      interval_reload_value <= ccit_pkg::RST_RELOAD;
    end
    else
    begin
      if (dp_write)
      begin
        case (dp_idx)
          ccit_pkg::IDX_CORE_SRC: core_clock_source_config <= {7'h00, hwdata[0]};
          ccit_pkg::IDX_TMR_CLK: timer_clock_config <= hwdata[7:0];
          ccit_pkg::IDX_CLK_PIN: clock_pin_config <= {3'h0, hwdata[4:0]};
          ccit_pkg::IDX_OSC_CTL: oscillator_control <= {2'h0, hwdata[5:0]};
          ccit_pkg::IDX_AUX_CTL: aux_control <= {4'h0, hwdata[3:0]};
          ccit_pkg::IDX_RELOAD: interval_reload_value <= hwdata[11:0];
          default: ;
        endcase
      end
      // sleep entry forces the internal oscillator; wins over a write
      if (sleep_req && !sleep_q)
        core_clock_source_config[ccit_pkg::CORE_SEL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_req;
  end
  assign osc24_run = !sleep_q;

  ////////////////////////////////////////////////////////////////////
  // external path and transient filter
  logic xtal_on, xtal_choose, filt_bypass;
  logic ext_clock_input_pin_raw, ext_clock_input_pin_filt, ext_path;
  logic [1:0] filt_cnt;
  assign xtal_on = clock_pin_config[ccit_pkg::XTAL_ON_BIT];
  assign xtal_choose = clock_pin_config[ccit_pkg::XTAL_CHOOSE_BIT];
  assign filt_bypass = clock_pin_config[ccit_pkg::FILT_BYPASS_BIT];
  assign crystal_osc_on = xtal_on;
  // clock input from crystal block when enabled, else shared pin zero
  assign ext_clock_input_pin_raw = xtal_on ? xtal : pin0;

  // short glitches shorter than the hold count never reach the clock tree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_cnt <= 2'd0;
      ext_clock_input_pin_filt <= 1'b0;
    end
    else if (ext_clock_input_pin_raw == ext_clock_input_pin_filt)
      filt_cnt <= 2'd0;
    else if (filt_cnt == 2'(ccit_pkg::FILT_HOLD - 1))
    begin
      filt_cnt <= 2'd0;
      ext_clock_input_pin_filt <= ext_clock_input_pin_raw;
    end
    else
      filt_cnt <= filt_cnt + 2'd1;
  end

  assign ext_path = xtal_choose ? xtal : (filt_bypass ? ext_clock_input_pin_raw : ext_clock_input_pin_filt);

  ////////////////////////////////////////////////////////////////////
  // glitch-free clock muxes
  logic [3:0] mux_src [4];
  logic [1:0] mux_want [4];
  logic [1:0] mux_cur [4];
  logic [3:0] mux_out;
  logic cap_clk, core_div;

  // core mux: 24 MHz, external, 32 kHz
  assign mux_src[ccit_pkg::MUX_CORE] = {1'b0, o32, ext_path, o24};
  assign mux_want[ccit_pkg::MUX_CORE] = aux_control[ccit_pkg::CORE_LP_BIT] ? 2'd2 :
    {1'b0, core_clock_source_config[ccit_pkg::CORE_SEL_BIT]};
  assign mux_src[ccit_pkg::MUX_ITMR] = {cap_clk, o32, ext_path, o24};
  assign mux_want[ccit_pkg::MUX_ITMR] = timer_clock_config[ccit_pkg::ITMR_SEL_LSB +: 2];
  // capture clock sources; code 11 is stopped
  assign mux_src[ccit_pkg::MUX_CAP] = {1'b0, o32, ext_path, o24};
  assign mux_want[ccit_pkg::MUX_CAP] = timer_clock_config[ccit_pkg::CAP_SEL_LSB +: 2];
  assign mux_src[ccit_pkg::MUX_PIN] = {core_div, o32, ext_path, o24};
  assign mux_want[ccit_pkg::MUX_PIN] = clock_pin_config[ccit_pkg::PIN_SRC_LSB +: 2];

  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mux
      // switch only while both old and new sources are low
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mux_cur[gi] <= 2'd0;
        else if (mux_want[gi] != mux_cur[gi] && !mux_src[gi][mux_cur[gi]] && !mux_src[gi][mux_want[gi]])
          mux_cur[gi] <= mux_want[gi];
      end
      assign mux_out[gi] = mux_src[gi][mux_cur[gi]];
    end
  endgenerate

  // a source that has stopped high holds the old selection; limitation of this scheme
  logic [3:0] mux_q;
  logic [3:0] mux_rise;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mux_q <= 4'h0;
    else
      mux_q <= mux_out;
  end
  assign mux_rise = mux_out & ~mux_q;

  ////////////////////////////////////////////////////////////////////
  // dividers
  function automatic logic [6:0] core_half(input logic [2:0] speed);
    case (speed)
      3'b000: core_half = 7'd4;
      3'b001: core_half = 7'd2;
      3'b010: core_half = 7'd1;
      3'b100: core_half = 7'd8;
      3'b101: core_half = 7'd16;
      3'b110: core_half = 7'd64;
      default: core_half = 7'd4;
    endcase
  endfunction

  logic [6:0] core_cnt;
  logic [6:0] core_lim;
  // half period in source edges; reserved codes act as 000
  assign core_lim = core_half(oscillator_control[ccit_pkg::SPEED_LSB +: 3]);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_cnt <= 7'd0;
      core_div <= 1'b0;
    end
    else if (mux_rise[ccit_pkg::MUX_CORE])
    begin
      if (core_cnt >= core_lim - 7'd1)
      begin
        core_cnt <= 7'd0;
        core_div <= !core_div;
      end
      else
        core_cnt <= core_cnt + 7'd1;
    end
  end
  assign core_clock = core_div;

  logic [1:0] cap_cnt;
  // toggle every 1..4 edges gives divide by 2, 4, 6, 8
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap_cnt <= 2'd0;
      cap_clk <= 1'b0;
    end
    else if (mux_rise[ccit_pkg::MUX_CAP])
    begin
      if (cap_cnt >= timer_clock_config[ccit_pkg::CAP_DIV_LSB +: 2])
      begin
        cap_cnt <= 2'd0;
        cap_clk <= !cap_clk;
      end
      else
        cap_cnt <= cap_cnt + 2'd1;
    end
  end

  logic [1:0] itmr_cnt;
  logic tmr_tick;
  // one tick every 1..4 source edges
  // reset value 24 MHz / 6 / 4 gives one tick per microsecond
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      itmr_cnt <= 2'd0;
      tmr_tick <= 1'b0;
    end
    else
    begin
      tmr_tick <= 1'b0;
      if (mux_rise[ccit_pkg::MUX_ITMR])
      begin
        if (itmr_cnt >= timer_clock_config[ccit_pkg::ITMR_DIV_LSB +: 2])
        begin
          itmr_cnt <= 2'd0;
          tmr_tick <= 1'b1;
        end
        else
          itmr_cnt <= itmr_cnt + 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interval timer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 12'h000;
      reloading <= 1'b0;
      itmr_irq <= 1'b0;
    end
    else
    begin
      itmr_irq <= 1'b0;
      if (tmr_tick)
      begin
        if (reloading)
        begin
          count <= interval_reload_value;
          reloading <= 1'b0;
          itmr_irq <= 1'b1;
        end
        else if (count == 12'h000)
          reloading <= 1'b1;
        else
          count <= count - 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sleep timer, watchdog period and detector duty
  logic [14:0] slp_cnt;
  logic [14:0] slp_mask;
  logic [1:0] wdt_cnt;
  logic [3:0] duty_cnt;
  logic [3:0] duty_mask;
  logic slp_tick;
  logic pin_q32;
  assign duty_mask = 4'((5'h1 << aux_control[ccit_pkg::DUTY_LSB +: 2]) - 5'h1);
  // 32 kHz divided by 64, 512, 4096 or 32768
  always_comb
  begin
    case (oscillator_control[ccit_pkg::SLEEP_TMR_LSB +: 2])
      2'b00: slp_mask = 15'h003f;
      2'b01: slp_mask = 15'h01ff;
      2'b10: slp_mask = 15'h0fff;
      default: slp_mask = 15'h7fff;
    endcase
  end
  assign slp_tick = o32 && !pin_q32 && ((slp_cnt & slp_mask) == slp_mask);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q32 <= 1'b0;
      slp_cnt <= 15'h0000;
      wdt_cnt <= 2'd0;
      sleep_wake <= 1'b0;
      wdt_expire <= 1'b0;
      duty_cnt <= 4'h0;
    end
    else
    begin
      pin_q32 <= o32;
      sleep_wake <= slp_tick && sleep_q;
      wdt_expire <= 1'b0;
      if (o32 && !pin_q32)
      begin
        slp_cnt <= slp_cnt + 15'h0001;
        // duty counter free of the sleep interval
        duty_cnt <= duty_cnt + 4'h1;
      end
      if (slp_tick)
      begin
        wdt_cnt <= (wdt_cnt == 2'd2) ? 2'd0 : wdt_cnt + 2'd1;
        wdt_expire <= wdt_cnt == 2'd2;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      detector_enable <= 1'b0;
    else
      // duty pulse during sleep, continuous while awake or when no-buzz is set
      detector_enable <= !sleep_req || oscillator_control[ccit_pkg::NO_BUZZ_BIT] || (duty_cnt & duty_mask) == 4'h0;
  end

  ////////////////////////////////////////////////////////////////////
  // shared pins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_output_pin <= 1'b0;
      shared_pin_one_oe <= 1'b0;
      shared_pin_zero_oe <= 1'b0;
    end
    else
    begin
      // clock pin source when the clock pin enable bit is set, else gpio_one_out
      clock_output_pin <= aux_control[ccit_pkg::CLKPIN_EN_BIT] ? mux_out[ccit_pkg::MUX_PIN] : gpio_one_out;
      // crystal blocks both shared pin enables
      shared_pin_one_oe <= !xtal_on && (aux_control[ccit_pkg::CLKPIN_EN_BIT] || gpio_one_oe);
      shared_pin_zero_oe <= !xtal_on && gpio_zero_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_count_down: assert property ((tmr_tick && !reloading && count != 12'h000) |=> count == $past(count) - 12'h001)
    else $error("interval counter did not step down");
  chk_zero_reload: assert property ((tmr_tick && !reloading && count == 12'h000) |=> reloading && !itmr_irq)
    else $error("zero count did not enter reload");
  chk_reload_irq: assert property ((tmr_tick && reloading) |=> itmr_irq && count == $past(interval_reload_value))
    else $error("reload did not load value with interrupt");
  chk_pin_oe_off: assert property (xtal_on |=> !shared_pin_zero_oe && !shared_pin_one_oe)
    else $error("shared pin driven while crystal enabled");
  chk_detector_on: assert property ((sleep_req && oscillator_control[ccit_pkg::NO_BUZZ_BIT]) |=> detector_enable)
    else $error("detector off during sleep with no-buzz");
  chk_sleep_force: assert property ((sleep_req && !sleep_q) |=> !core_clock_source_config[ccit_pkg::CORE_SEL_BIT] ##1 !osc24_run)
    else $error("sleep entry did not force internal oscillator");
  chk_mux_glitch: assert property ((mux_cur[ccit_pkg::MUX_CORE] != $past(mux_cur[ccit_pkg::MUX_CORE])) |-> !$past(mux_out[ccit_pkg::MUX_CORE]))
    else $error("core mux switched during a high phase");
  chk_pin_source: assert property ((aux_control[ccit_pkg::CLKPIN_EN_BIT] && $stable(aux_control)) |=> clock_output_pin == $past(mux_out[ccit_pkg::MUX_PIN]))
    else $error("clock pin not following its source");

  cov_irq: cover property (itmr_irq ##[1:100] itmr_irq);
  cov_sleep: cover property (sleep_req && !sleep_q ##[1:50] sleep_wake);
  cov_xtal: cover property (xtal_on && xtal_choose && mux_cur[ccit_pkg::MUX_CORE] == 2'd1);
endmodule // ccit_top
`default_nettype wire

// [ccit_xtal_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ccit_xtal_model
#(
  parameter int START_NS = 2000,
  parameter int HALF_NS = 36
)
(
  // enable from the block
  input wire logic osc_on,
  // clocks towards the block
  output logic xtal_clk,
  output logic pin_clk
);
  logic running = 1'b0;
  initial xtal_clk = 1'b0;
  initial pin_clk = 1'b0;
  ////////////////////////////////////////////////////////////////
  // start-up delay
  always
  begin
    @(posedge osc_on);
    #(START_NS);
    running = osc_on;
  end
  always @(negedge osc_on) running = 1'b0;
  // a stopped crystal rests low, never frozen mid-phase
  always #(HALF_NS) xtal_clk = running ? ~xtal_clk : 1'b0;
  // pin clock is a free-running generator, unrelated in phase
  always #(HALF_NS + 7) pin_clk = ~pin_clk;
endmodule // ccit_xtal_model
`default_nettype wire

// [test_clock_select_and_interval_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_clock_select_and_interval_timer;
  localparam int OSC_DIV = 6;
  localparam logic [9:0] IDX [5] = '{ccit_pkg::IDX_CORE_SRC, ccit_pkg::IDX_TMR_CLK, ccit_pkg::IDX_CLK_PIN,
    ccit_pkg::IDX_OSC_CTL, 10'h3ff};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h8f, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WM [5] = '{8'h01, 8'hff, 8'h1f, 8'h3f, 8'h00};
  localparam int SDIV [6] = '{8, 4, 2, 16, 32, 128};
  localparam logic [2:0] SCODE [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic clk = 1'b0, resetn = 1'b0, hwrite = 1'b0, sleep_req = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata, seed = 32'h6789c205;
  logic osc24_in = 1'b0, osc32_in = 1'b0, g0oe = 1'b0, g1out = 1'b0, g1oe = 1'b0;
  logic hreadyout, hresp, spz_oe, cpin, spo_oe, core_clock, osc24_run, xtal_on;
  logic det_en, sleep_wake, wdt_expire, itmr_irq, xtal_clk, pin_clk;
  int cyc = 0, n_fail = 0, cmp_count = 0;
  ////////////////////////////////////////////////////////////////
  ccit_top u_dut (.clk(clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(ccit_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .osc24_in(osc24_in), .osc32_in(osc32_in), .xtal_clk_in(xtal_clk),
    .shared_pin_zero_in(pin_clk), .gpio_zero_oe(g0oe), .gpio_one_out(g1out), .gpio_one_oe(g1oe),
    .shared_pin_zero_oe(spz_oe), .clock_output_pin(cpin), .shared_pin_one_oe(spo_oe), .core_clock(core_clock),
    .osc24_run(osc24_run), .crystal_osc_on(xtal_on), .sleep_req(sleep_req), .detector_enable(det_en),
    .sleep_wake(sleep_wake), .wdt_expire(wdt_expire), .itmr_irq(itmr_irq));
  ccit_xtal_model u_xtal (.osc_on(xtal_on), .xtal_clk(xtal_clk), .pin_clk(pin_clk));
  ////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  // oscillators derived from the bench clock so tick spacing is exact
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    osc24_in <= (cyc % OSC_DIV) < (OSC_DIV / 2);
    osc32_in <= (cyc % 64) < 32;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one single word transfer; entered just after a rising edge
  task xfer(input logic w, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    haddr <= {idx, 2'b00};
    htrans <= ccit_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
    chk(32'(k < 100), 32'd1);
  endtask
  // cycle number of the next rising edge: irq 0, core clock 1, wake 2, watchdog 3, clock pin 4
  task wait_rise(input logic [2:0] sel, output int t);
    int k;
    logic p, s;
    k = 0;
    s = 1'b1;
    do
    begin
      p = s;
      @(posedge clk);
      s = sel == 3'd4 ? cpin : sel == 3'd3 ? wdt_expire : sel == 3'd2 ? sleep_wake :
        sel == 3'd1 ? core_clock : itmr_irq;
      k++;
    end
    while (!(s === 1'b1 && p === 1'b0) && k < 13000);
    t = cyc;
    chk(32'(k < 13000), 32'd1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #800000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    int t0, t1, r, d;
    logic [31:0] rd;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // defaults: 24 MHz source /6 then /4, reload 0 gives two ticks per interrupt
    wait_rise(3'd0, t0);
    wait_rise(3'd0, t0);
    wait_rise(3'd0, t1);
    chk(32'(t1 - t0), 32'(2 * OSC_DIV * 6 * 4));
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, IDX[i], 32'h0, rd);
      chk(rd, {24'h0, RV[i]});
      xfer(1'b1, IDX[i], 32'hff, rd);
      xfer(1'b0, IDX[i], 32'h0, rd);
      chk(rd, {24'h0, WM[i]});
      xfer(1'b1, IDX[i], 32'h0, rd);
    end
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, ccit_pkg::IDX_OSC_CTL, {29'h0, SCODE[i]}, rd);
      wait_rise(3'd1, t0);
      wait_rise(3'd1, t0);
      wait_rise(3'd1, t1);
      chk(32'(t1 - t0), 32'(SDIV[i] * OSC_DIV));
    end
    xfer(1'b1, ccit_pkg::IDX_OSC_CTL, 32'h0, rd);
    for (int i = 0; i < 5; i++)
    begin
      r = 1 + int'(rnd() % 20);
      d = int'(rnd() % 4);
      xfer(1'b1, ccit_pkg::IDX_TMR_CLK, 32'h80 | 32'(d << 2), rd);
      xfer(1'b1, ccit_pkg::IDX_RELOAD, 32'(r), rd);
      xfer(1'b0, ccit_pkg::IDX_RELOAD, 32'h0, rd);
      chk(rd, 32'(r));
      wait_rise(3'd0, t0);
      wait_rise(3'd0, t0);
      wait_rise(3'd0, t1);
      chk(32'(t1 - t0), 32'((r + 2) * OSC_DIV * (d + 1)));
    end
    g0oe <= 1'(rnd());
    g1oe <= 1'b1;
    xfer(1'b1, ccit_pkg::IDX_CLK_PIN, 32'h00, rd);
    repeat (4) @(posedge clk);
    chk(32'(spz_oe), 32'(g0oe));
    g0oe <= 1'b1;
    xfer(1'b1, ccit_pkg::IDX_CLK_PIN, 32'h08, rd);
    repeat (4) @(posedge clk);
    chk(32'({xtal_on, spz_oe, spo_oe}), 32'h4);
    repeat (300) @(posedge clk);
    xfer(1'b1, ccit_pkg::IDX_CLK_PIN, 32'h18, rd);
    xfer(1'b1, ccit_pkg::IDX_TMR_CLK, 32'h81, rd);
    wait_rise(3'd0, t0);
    xfer(1'b1, ccit_pkg::IDX_TMR_CLK, 32'h80, rd);
    xfer(1'b1, ccit_pkg::IDX_CLK_PIN, 32'h08, rd);
    xfer(1'b1, ccit_pkg::IDX_CLK_PIN, 32'h00, rd);
    // clock pin from the 32 kHz source: one period per 64 bench cycles
    xfer(1'b1, ccit_pkg::IDX_AUX_CTL, 32'h2, rd);
    xfer(1'b1, ccit_pkg::IDX_CLK_PIN, 32'h2, rd);
    wait_rise(3'd4, t0);
    wait_rise(3'd4, t0);
    wait_rise(3'd4, t1);
    chk(32'(t1 - t0), 32'h40);
    xfer(1'b1, ccit_pkg::IDX_CORE_SRC, 32'h1, rd);
    xfer(1'b1, ccit_pkg::IDX_OSC_CTL, 32'h20, rd);
    sleep_req <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(osc24_run), 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      chk(32'(det_en), 32'h1);
    end
    // sleep timer field 00: a tick every 64 edges of the 32 kHz source, watchdog every third
    wait_rise(3'd2, t0);
    wait_rise(3'd2, t1);
    chk(32'(t1 - t0), 32'(64 * 64));
    wait_rise(3'd3, t0);
    wait_rise(3'd3, t1);
    chk(32'(t1 - t0), 32'(3 * 64 * 64));
    xfer(1'b0, ccit_pkg::IDX_CORE_SRC, 32'h0, rd);
    chk(rd, 32'h0);
    sleep_req <= 1'b0;
    tally_and_finish();
  end
endmodule // test_clock_select_and_interval_timer
`default_nettype wire
